// File: common/remote_cmd_defs.svh
// constants for the remote command handshake block
`ifndef REMOTE_CMD_DEFS_SVH
`define REMOTE_CMD_DEFS_SVH
`define A_CTRL 4'h0
`define A_STATUS 4'h1
`define A_IRQ_STAT 4'h2
`define A_IRQ_CLR 4'h3
`define A_IRQ_EN 4'h4
`define A_GP_FUNC 4'h5
`define A_NV_FREQ 4'h6
`define A_RAM_FREQ 4'h7
`define A_RAM_TRQ 4'h8
`define A_REPLY_SEL 4'h9
`define A_REPLY 4'ha
`define A_EXEC_PEND 4'hb
`define A_EXEC_DONE 4'hc
`define CTRL_RESET 8'h00
`define IRQ_FREQ 0
`define IRQ_PERS 1
`define IRQ_EXEC 2
`define IRQ_FAULT 3
`define IRQ_RESET 4
`define NV_WRITE_TIME_NS 200
`define CLK_PERIOD_NS 20
`define NV_WRITE_CYC ((`NV_WRITE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define INIT_CYC 16'h0010
`endif

// File: common/remote_cmd_pkg.sv
// types for the remote command handshake block
package remote_cmd_pkg;
  typedef struct packed {
    logic freq_write_ram_cmd;
    logic freq_write_persist_cmd;
    logic instr_exec_request;
    logic fault_reset_request;
    logic net_input_gp3;
    logic net_input_gp4;
    logic net_input_gp5;
  } cmd_bits_t;
  typedef struct packed {
    logic freq_write_ram_done;
    logic freq_write_persist_done;
    logic instr_exec_done;
    logic fault_status_flag;
    logic station_ready_flag;
  } ret_bits_t;
  typedef enum logic [4:0] {
    S_INIT = 5'b00001,
    S_IDLE = 5'b00010,
    S_NVW = 5'b00100,
    S_EXEC = 5'b01000,
    S_RST = 5'b10000
  } state_t;
endpackage

// File: rtl/remote_command_handshake.sv
// cyclic command interpreter: frequency writes, instruction batch, fault reset
//
// Notes on behaviour
// - volatile write command copies set frequency to RAM, then RAM done asserted
// - while volatile command held, set frequency is applied every cycle
// - persistent command stores word in RAM and non-volatile memory first
// - persistent done set only after both writes finished
// - vector modes also store torque command or torque limit simultaneously
// - rising edge of execution request runs the six instruction slots
// - execution done set once every slot processed
// - failed slot gets nonzero reply code; zero means success
// - fault reset request during fault resets device then clears fault flag
// - general-purpose net inputs do nothing until a function is assigned
// - command-source settings make the device ignore some command bits
// - fixed-function bits cannot be reassigned by configuration
// - torque control refused when a permanent-magnet motor is configured
// - dropping a write command drops its matching completion bit
// - protective trip sets fault flag and drops station ready
// - station ready only after initial setup completes
`timescale 1ns/1ps
`include "remote_cmd_defs.svh"
module remote_command_handshake #(
  parameter int SLOTS = 6,
  parameter int WORD_W = 16
) (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic exchange_strobe_i,
  input wire remote_cmd_pkg::cmd_bits_t cmd_i,
  input wire logic [WORD_W-1:0] set_frequency_word_i,
  input wire logic [WORD_W-1:0] torque_value_i,
  input wire logic [SLOTS*WORD_W-1:0] instr_code_slot_i,
  input wire logic protect_trip_i,
  input wire logic [3:0] reg_addr_i,
  input wire logic [15:0] reg_wdata_i,
  input wire logic reg_write_i,
  input wire logic reg_read_i,
  output remote_cmd_pkg::ret_bits_t ret_o,
  output logic [WORD_W-1:0] applied_freq_o,
  output logic [2:0] gp_input_active_o,
  output logic irq_o,
  output logic [15:0] reg_rdata_o
);
  // ctrl bits: 0 vector mode, 1 torque ctrl, 2 pm motor, 3 net freq src,
  // 4 net start src, 7:5 unused (gp3..gp5 enables are in the gp function register)
  logic [7:0] ctrl_q;
  logic [2:0] gp_func_q;
  remote_cmd_pkg::cmd_bits_t cmd_q, cmd_prev_q;
  remote_cmd_pkg::ret_bits_t ret_q;
  remote_cmd_pkg::state_t state_q;
  logic [WORD_W-1:0] ram_freq_q, nv_freq_q, ram_trq_q, nv_trq_q, applied_q;
  logic [WORD_W-1:0] reply_q [SLOTS];
  logic [15:0] cnt_q;
  logic [2:0] slot_q, reply_sel_q;
  logic [4:0] irq_stat_q, irq_en_q;
  logic irq_q;
  logic [15:0] rdata_q;
  logic [2:0] gp_q;
  logic exec_pend_q;
  logic exec_all_q;
  logic nv_pend_q;
  // high the cycle after an exchange, so an edge is seen exactly once
  logic strobe_q;

  // instruction codes: valid when upper byte is 0x00 or 0x80; else error
  function automatic logic [WORD_W-1:0] run_code(input logic [WORD_W-1:0] code);
    logic [7:0] hi;
    hi = code[WORD_W-1 -: 8];
    run_code = (hi == 8'h00 || hi == 8'h80) ? '0 : {{(WORD_W-8){1'b0}}, 8'h01};
  endfunction

  wire torque_mode_w = ctrl_q[1] & ~ctrl_q[2];
  wire vector_w = ctrl_q[0];
  // frequency writes honoured only when the network is the frequency source
  wire freq_src_net_w = ctrl_q[3];
  wire start_src_net_w = ctrl_q[4];
  wire ram_cmd_w = cmd_q.freq_write_ram_cmd & freq_src_net_w;
  wire pers_cmd_w = cmd_q.freq_write_persist_cmd & freq_src_net_w;
  wire exec_edge_w = strobe_q & cmd_q.instr_exec_request & ~cmd_prev_q.instr_exec_request;
  wire rst_req_w = cmd_q.fault_reset_request & ret_q.fault_status_flag;
  wire [2:0] gp_raw_w = {cmd_q.net_input_gp5, cmd_q.net_input_gp4, cmd_q.net_input_gp3};
  wire [2:0] gp_w = gp_raw_w & gp_func_q & {3{start_src_net_w}};
  wire [WORD_W-1:0] slot_code_w = instr_code_slot_i[slot_q*WORD_W +: WORD_W];
  wire wr_ctrl_w = reg_write_i && reg_addr_i == `A_CTRL;
  wire wr_clr_w = reg_write_i && reg_addr_i == `A_IRQ_CLR;
  wire wr_en_w = reg_write_i && reg_addr_i == `A_IRQ_EN;
  wire wr_gp_w = reg_write_i && reg_addr_i == `A_GP_FUNC;
  wire wr_sel_w = reg_write_i && reg_addr_i == `A_REPLY_SEL;
  wire [4:0] ev_w;
  wire nv_done_w = state_q == remote_cmd_pkg::S_NVW && cnt_q == 16'h0001;
  wire exec_done_w = state_q == remote_cmd_pkg::S_EXEC && slot_q == 3'(SLOTS - 1);
  wire rst_done_w = state_q == remote_cmd_pkg::S_RST && cnt_q == 16'h0001;
  wire ram_set_w = ram_cmd_w & ~ret_q.freq_write_ram_done;
  assign ev_w[`IRQ_FREQ] = ram_set_w;
  assign ev_w[`IRQ_PERS] = nv_done_w;
  assign ev_w[`IRQ_EXEC] = exec_done_w;
  assign ev_w[`IRQ_FAULT] = protect_trip_i & ~ret_q.fault_status_flag;
  assign ev_w[`IRQ_RESET] = rst_done_w;

  logic [15:0] rd_mux_w;
  always_comb begin
    rd_mux_w = 16'h0000;
    case (reg_addr_i)
      `A_CTRL: rd_mux_w = {8'h00, ctrl_q};
      `A_STATUS: rd_mux_w = {5'h00, torque_mode_w, state_q, ret_q};
      `A_IRQ_STAT: rd_mux_w = {11'h000, irq_stat_q};
      `A_IRQ_EN: rd_mux_w = {11'h000, irq_en_q};
      `A_GP_FUNC: rd_mux_w = {13'h0000, gp_func_q};
      `A_NV_FREQ: rd_mux_w = 16'(nv_freq_q);
      `A_RAM_FREQ: rd_mux_w = 16'(ram_freq_q);
      `A_RAM_TRQ: rd_mux_w = 16'(ram_trq_q);
      `A_REPLY_SEL: rd_mux_w = {13'h0000, reply_sel_q};
      `A_REPLY: rd_mux_w = 16'(reply_q[reply_sel_q]);
      `A_EXEC_PEND: rd_mux_w = {14'h0000, exec_all_q, exec_pend_q};
      `A_EXEC_DONE: rd_mux_w = {15'h0000, nv_pend_q};
      default: rd_mux_w = 16'h0000;
    endcase
  end

  // register port
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ctrl_q <= `CTRL_RESET;
      gp_func_q <= 3'h0;
      irq_en_q <= 5'h00;
      irq_stat_q <= 5'h00;
      reply_sel_q <= 3'h0;
      rdata_q <= 16'h0000;
      irq_q <= 1'b0;
    end else begin
      if (wr_ctrl_w) ctrl_q <= reg_wdata_i[7:0];
      if (wr_gp_w) gp_func_q <= reg_wdata_i[2:0];
      if (wr_en_w) irq_en_q <= reg_wdata_i[4:0];
      if (wr_sel_w) reply_sel_q <= reg_wdata_i[2:0];
      // set wins over a simultaneous clear
      irq_stat_q <= (irq_stat_q & ~(wr_clr_w ? reg_wdata_i[4:0] : 5'h00)) | ev_w;
      rdata_q <= reg_read_i ? rd_mux_w : 16'h0000;
      irq_q <= |(irq_stat_q & irq_en_q);
    end
  end

  // command sampling, once per cyclic exchange
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      cmd_q <= '0;
      cmd_prev_q <= '0;
      strobe_q <= 1'b0;
    end else begin
      strobe_q <= exchange_strobe_i;
      if (exchange_strobe_i) begin
        cmd_q <= cmd_i;
        cmd_prev_q <= cmd_q;
      end
    end
  end

  // volatile write, RAM copy after a persistent write, gp input register
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      ram_freq_q <= '0;
      ram_trq_q <= '0;
      applied_q <= '0;
      gp_q <= 3'h0;
    end else begin
      gp_q <= gp_w;
      if (ram_cmd_w) begin
        ram_freq_q <= set_frequency_word_i;
        applied_q <= set_frequency_word_i;
        if (vector_w) ram_trq_q <= torque_value_i;
      end else if (nv_done_w) begin
        ram_freq_q <= nv_freq_q;
        applied_q <= nv_freq_q;
        if (vector_w) ram_trq_q <= nv_trq_q;
      end
    end
  end

  // sequencer: init, non-volatile write, instruction batch, fault reset
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      state_q <= remote_cmd_pkg::S_INIT;
      cnt_q <= `INIT_CYC;
      slot_q <= 3'h0;
      nv_freq_q <= '0;
      nv_trq_q <= '0;
      for (int i = 0; i < SLOTS; i++) reply_q[i] <= '0;
      ret_q.freq_write_ram_done <= 1'b0;
      ret_q.freq_write_persist_done <= 1'b0;
      ret_q.instr_exec_done <= 1'b0;
      ret_q.fault_status_flag <= 1'b0;
      ret_q.station_ready_flag <= 1'b0;
      exec_pend_q <= 1'b0;
      exec_all_q <= 1'b0;
      nv_pend_q <= 1'b0;
    end else begin
      if (exec_edge_w) exec_pend_q <= 1'b1;
      // done once RAM holds the word, then stands until the command drops
      ret_q.freq_write_ram_done <= ram_cmd_w &
        (ret_q.freq_write_ram_done | (ram_freq_q == set_frequency_word_i));
      if (!cmd_q.instr_exec_request) ret_q.instr_exec_done <= 1'b0;
      if (!pers_cmd_w) ret_q.freq_write_persist_done <= 1'b0;
      if (pers_cmd_w && !ret_q.freq_write_persist_done) nv_pend_q <= 1'b1;
      if (protect_trip_i) begin
        ret_q.fault_status_flag <= 1'b1;
        ret_q.station_ready_flag <= 1'b0;
      end
      case (state_q)
        remote_cmd_pkg::S_INIT: begin
          cnt_q <= cnt_q - 16'h0001;
          if (cnt_q == 16'h0001) begin
            state_q <= remote_cmd_pkg::S_IDLE;
            ret_q.station_ready_flag <= ~protect_trip_i;
          end
        end
        remote_cmd_pkg::S_IDLE: begin
          if (rst_req_w) begin
            state_q <= remote_cmd_pkg::S_RST;
            cnt_q <= `INIT_CYC;
          end else if (nv_pend_q && pers_cmd_w && !ret_q.freq_write_persist_done) begin
            nv_freq_q <= set_frequency_word_i;
            if (vector_w) nv_trq_q <= torque_value_i;
            cnt_q <= 16'(`NV_WRITE_CYC);
            state_q <= remote_cmd_pkg::S_NVW;
          end else if (exec_pend_q) begin
            exec_pend_q <= exec_edge_w;
            slot_q <= 3'h0;
            state_q <= remote_cmd_pkg::S_EXEC;
          end
        end
        remote_cmd_pkg::S_NVW: begin
          cnt_q <= cnt_q - 16'h0001;
          if (nv_done_w) begin
            nv_pend_q <= 1'b0;
            ret_q.freq_write_persist_done <= pers_cmd_w;
            state_q <= remote_cmd_pkg::S_IDLE;
          end
        end
        remote_cmd_pkg::S_EXEC: begin
          reply_q[slot_q] <= run_code(slot_code_w);
          slot_q <= slot_q + 3'h1;
          if (exec_done_w) begin
            exec_all_q <= 1'b1;
            ret_q.instr_exec_done <= cmd_q.instr_exec_request;
            state_q <= remote_cmd_pkg::S_IDLE;
          end
        end
        remote_cmd_pkg::S_RST: begin
          cnt_q <= cnt_q - 16'h0001;
          if (rst_done_w) begin
            ret_q.fault_status_flag <= protect_trip_i;
            ret_q.station_ready_flag <= ~protect_trip_i;
            state_q <= remote_cmd_pkg::S_IDLE;
          end
        end
        default: state_q <= remote_cmd_pkg::S_IDLE;
      endcase
    end
  end

  assign ret_o = ret_q;
  assign applied_freq_o = applied_q;
  assign gp_input_active_o = gp_q;
  assign irq_o = irq_q;
  assign reg_rdata_o = rdata_q;
endmodule

// File: tb/net_master_model.sv
// network master model: cyclic exchange strobe and four-phase command handshakes
`timescale 1ns/1ps
module net_master_model (
  input wire logic clk_i,
  input wire remote_cmd_pkg::ret_bits_t ret_i,
  output logic exchange_strobe_o,
  output remote_cmd_pkg::cmd_bits_t cmd_o
);
  logic [1:0] phase_q = 2'h0;
  initial begin
    exchange_strobe_o = 1'b0;
    cmd_o = '0;
  end
  // one exchange every four clocks, slower than the block so sampling is visible
  always @(posedge clk_i) begin
    phase_q <= phase_q + 2'h1;
    exchange_strobe_o <= (phase_q == 2'h3);
  end
  function automatic logic done_of(input int k);
    return k == 0 ? ret_i.freq_write_ram_done :
           k == 1 ? ret_i.freq_write_persist_done : ret_i.instr_exec_done;
  endfunction
  // set or drop request k, then wait (bounded) until its done bit follows
  task automatic step_cmd(input int k, input logic v, output int n);
    case (k)
      0: cmd_o.freq_write_ram_cmd <= v;
      1: cmd_o.freq_write_persist_cmd <= v;
      default: cmd_o.instr_exec_request <= v;
    endcase
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (done_of(k) !== v && n < 200);
  endtask
  task automatic set_aux(input logic [2:0] gp, input logic fr);
    {cmd_o.net_input_gp3, cmd_o.net_input_gp4, cmd_o.net_input_gp5} <= gp;
    cmd_o.fault_reset_request <= fr;
  endtask
endmodule

// File: tb/remote_command_handshake_monitor.sv
// port-level checks for the remote command handshake block
`timescale 1ns/1ps
module remote_command_handshake_monitor (
  input wire logic clk_i,
  input wire logic reset_n_i,
  input wire logic exchange_strobe_i,
  input wire remote_cmd_pkg::cmd_bits_t cmd_i,
  input wire logic protect_trip_i,
  input wire remote_cmd_pkg::ret_bits_t ret_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (!reset_n_i);
  // last sampled request levels, so only a fresh request starts the timing checks
  logic pers_q;
  logic exec_q;
  always_ff @(posedge clk_i) begin
    if (!reset_n_i) begin
      pers_q <= 1'b0;
      exec_q <= 1'b0;
    end else if (exchange_strobe_i) begin
      pers_q <= cmd_i.freq_write_persist_cmd;
      exec_q <= cmd_i.instr_exec_request;
    end
  end
  chk_trip_sets_fault: assert property (protect_trip_i |-> ##[1:4] ret_o.fault_status_flag)
    else $error("trip did not raise fault flag");
  chk_fault_holds: assert property (ret_o.fault_status_flag && !cmd_i.fault_reset_request |=> ret_o.fault_status_flag)
    else $error("fault flag dropped without reset request");
  chk_reset_clears: assert property (exchange_strobe_i && cmd_i.fault_reset_request && !protect_trip_i |-> ##[1:60] !ret_o.fault_status_flag)
    else $error("fault reset did not clear flag");
  chk_ready_after_init: assert property ($rose(reset_n_i) |-> !ret_o.station_ready_flag [*8])
    else $error("ready before setup finished");
  chk_ram_done_drop: assert property (exchange_strobe_i && !cmd_i.freq_write_ram_cmd |-> ##[1:4] !ret_o.freq_write_ram_done)
    else $error("ram done stayed after command dropped");
  chk_pers_done_drop: assert property (exchange_strobe_i && !cmd_i.freq_write_persist_cmd |-> ##[1:4] !ret_o.freq_write_persist_done)
    else $error("persist done stayed after command dropped");
  chk_pers_not_early: assert property (exchange_strobe_i && cmd_i.freq_write_persist_cmd && !pers_q |=> !ret_o.freq_write_persist_done [*8])
    else $error("persist done before write time");
  chk_exec_not_early: assert property (exchange_strobe_i && cmd_i.instr_exec_request && !exec_q |=> !ret_o.instr_exec_done [*5])
    else $error("exec done before slots processed");
endmodule
bind remote_command_handshake remote_command_handshake_monitor remote_command_handshake_monitor_i (
  .clk_i(clk_i),
  .reset_n_i(reset_n_i),
  .exchange_strobe_i(exchange_strobe_i),
  .cmd_i(cmd_i),
  .protect_trip_i(protect_trip_i),
  .ret_o(ret_o)
);

// File: tb/remote_command_handshake_tb_top.sv
// self-checking bench for the remote command handshake block
`timescale 1ns/1ps
`include "remote_cmd_defs.svh"
`define CHK(a, b) begin check_count++; if ((a) !== (b)) begin mismatches++; \
  $display("[ERR] %0t mismatch %h vs %h", $time, a, b); end end
module remote_command_handshake_tb_top;
  logic clk_i = 1'b0;
  logic reset_n_i = 1'b0;
  logic trip = 1'b0;
  logic wr = 1'b0;
  logic rd = 1'b0;
  logic [3:0] addr = 4'h0;
  logic [15:0] wdata = 16'h0000, freq = 16'h0000, trq = 16'h0000, rdata, applied, v;
  logic [95:0] codes = '0, c;
  logic strobe, irq;
  logic [2:0] gp;
  remote_cmd_pkg::cmd_bits_t cmd;
  remote_cmd_pkg::ret_bits_t ret;
  int mismatches = 0, check_count = 0, seed = 32'hfbec, lat, i;
  initial begin
    forever #10 clk_i = ~clk_i;
  end
  remote_command_handshake remote_command_handshake_i (.clk_i(clk_i), .reset_n_i(reset_n_i),
    .exchange_strobe_i(strobe), .cmd_i(cmd), .set_frequency_word_i(freq), .torque_value_i(trq),
    .instr_code_slot_i(codes), .protect_trip_i(trip), .reg_addr_i(addr), .reg_wdata_i(wdata),
    .reg_write_i(wr), .reg_read_i(rd), .ret_o(ret), .applied_freq_o(applied),
    .gp_input_active_o(gp), .irq_o(irq), .reg_rdata_o(rdata));
  net_master_model net_master_model_i (.clk_i(clk_i), .ret_i(ret), .exchange_strobe_o(strobe),
    .cmd_o(cmd));
  task automatic reg_wr(input logic [3:0] a, input logic [15:0] d);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_i);
    wr <= 1'b0;
    @(posedge clk_i);
  endtask
  task automatic reg_rd(input logic [3:0] a, output logic [15:0] d);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_i);
    rd <= 1'b0;
    @(posedge clk_i);
    d = rdata;
  endtask
  task automatic step(input int k, input logic lvl);
    net_master_model_i.step_cmd(k, lvl, lat);
    if (lat >= 200) begin
      mismatches++;
      $display("[ERR] %0t handshake timeout", $time);
      stop_test();
    end
  endtask
  function automatic logic [15:0] exp_reply(input logic [15:0] k);
    return (k[15:8] == 8'h00 || k[15:8] == 8'h80) ? 16'h0000 : 16'h0001;
  endfunction
  task automatic stop_test;
    $display("checks %0d mismatches %0d", check_count, mismatches);
    if (mismatches == 0 && check_count > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    reset_n_i <= 1'b1;
    repeat (12) @(posedge clk_i);
    `CHK(ret.station_ready_flag, 1'b0)
    repeat (10) @(posedge clk_i);
    `CHK(ret.station_ready_flag, 1'b1)
    net_master_model_i.step_cmd(0, 1'b1, lat);
    `CHK(lat, 200)
    step(0, 1'b0);
    reg_wr(`A_CTRL, 16'h0019);
    reg_wr(`A_IRQ_EN, 16'h0004);
    freq <= 16'($random(seed));
    trq <= 16'($random(seed));
    step(0, 1'b1);
    `CHK(applied, freq)
    reg_rd(`A_RAM_TRQ, v);
    `CHK(v, trq)
    freq <= 16'($random(seed));
    repeat (12) @(posedge clk_i);
    `CHK(applied, freq)
    step(0, 1'b0);
    `CHK(lat < 200, 1'b1)
    reg_rd(`A_IRQ_STAT, v);
    `CHK(v[0], 1'b1)
    `CHK(irq, 1'b0)
    freq <= 16'($random(seed));
    step(1, 1'b1);
    `CHK(lat >= 10 && lat < 200, 1'b1)
    reg_rd(`A_NV_FREQ, v);
    `CHK(v, freq)
    step(1, 1'b0);
    for (i = 0; i < 6; i++) begin
      c[i*16 +: 16] = 16'($random(seed));
    end
    c[15:8] = 8'h00;
    c[31:24] = 8'h80;
    c[47:40] = 8'h7f;
    codes <= c;
    step(2, 1'b1);
    `CHK(lat >= 6 && lat < 200, 1'b1)
    for (i = 0; i < 6; i++) begin
      reg_wr(`A_REPLY_SEL, 16'(i));
      reg_rd(`A_REPLY, v);
      `CHK(v, exp_reply(c[i*16 +: 16]))
    end
    `CHK(irq, 1'b1)
    step(2, 1'b0);
    reg_wr(`A_IRQ_CLR, 16'h001f);
    @(posedge clk_i);
    `CHK(irq, 1'b0)
    reg_rd(4'hf, v);
    `CHK(v, 16'h0000)
    reg_wr(`A_CTRL, 16'h001b);
    reg_rd(`A_STATUS, v);
    `CHK(v[10], 1'b1)
    reg_wr(`A_CTRL, 16'h001f);
    reg_rd(`A_STATUS, v);
    `CHK(v[10], 1'b0)
    reg_wr(`A_CTRL, 16'h0019);
    net_master_model_i.set_aux(3'b111, 1'b0);
    repeat (8) @(posedge clk_i);
    `CHK(gp, 3'b000)
    reg_wr(`A_GP_FUNC, 16'h0007);
    repeat (8) @(posedge clk_i);
    `CHK(gp, 3'b111)
    trip <= 1'b1;
    repeat (6) @(posedge clk_i);
    `CHK(ret.station_ready_flag, 1'b0)
    trip <= 1'b0;
    repeat (8) @(posedge clk_i);
    `CHK(ret.fault_status_flag, 1'b1)
    net_master_model_i.set_aux(3'b000, 1'b1);
    lat = 0;
    do begin
      @(posedge clk_i);
      lat++;
    end while (ret.fault_status_flag !== 1'b0 && lat < 200);
    net_master_model_i.set_aux(3'b000, 1'b0);
    `CHK(ret.fault_status_flag, 1'b0)
    reg_rd(`A_IRQ_STAT, v);
    `CHK(v, 16'h0018)
    stop_test();
  end
endmodule
